// >>> verilog/xdata_pkg.sv
// Functional notes
// R1 - each move starts with a four-clock opcode fetch machine cycle
// R2 - the next machine cycle drives the data address and performs the access
// R3 - stretch_select is bits 2..0 of clock_control_reg, eight settings
// R4 - stretch 0..7 gives a move of stretch plus two machine cycles
// R5 - stretching lengthens only the move, as if the cpu state were held
// R6 - stretch resets to one; zero gives the fastest two-cycle move
// R7 - strobe width is 2 clocks at stretch 0, else four clocks per step
// R8 - wait input exists only as alternate use of port_four_bit_zero
// R9 - wait handling acts only while wait_enable, bit 7 of memory_map_control, is set
// R10 - with waits enabled the stretch still sets the minimum move length
// R11 - wait is sampled in the last third_state before the strobe release
// R12 - each recognised wait inserts one more machine cycle
// R13 - waits are unlimited; the move ends once wait is seen inactive
// R14 - the peripheral holds wait until ready, then releases it
// R15 - wait_enable only changes after the timed-access unlock sequence
// R16 - a machine cycle is four states, first to fourth, in order
// R17 - index access: low byte from index_register, high byte from port two latch
// R18 - data_pointer_select bit 0 picks the pointer; other bits read zero
// R19 - address and strobe stay steady while wait cycles are inserted
//
// Purpose: constants for the external data access sequencer
// Assumes: ahb-lite register access, 32-bit words
// Notes:   offsets are byte addresses
package xdata_pkg;
    localparam logic [7:0]  OFF_CLOCK_CONTROL   = 8'h00;
    localparam logic [7:0]  OFF_MEMORY_MAP      = 8'h04;
    localparam logic [7:0]  OFF_TIMED_ACCESS    = 8'h08;
    localparam logic [7:0]  OFF_POINTER_SELECT  = 8'h0c;
    localparam logic [7:0]  OFF_PRIMARY_PTR     = 8'h10;
    localparam logic [7:0]  OFF_SECONDARY_PTR   = 8'h14;
    localparam logic [7:0]  OFF_INDEX_REGISTER  = 8'h18;
    localparam logic [7:0]  OFF_PORT_TWO_LATCH  = 8'h1c;
    localparam logic [7:0]  OFF_WRITE_DATA      = 8'h20;
    localparam logic [7:0]  OFF_COMMAND         = 8'h24;
    localparam logic [7:0]  OFF_STATUS          = 8'h28;
    localparam int          WAIT_ENABLE_BIT     = 7;
    localparam int          CMD_STORE_BIT       = 0;
    localparam int          CMD_INDEX_BIT       = 1;
    localparam int          ST_BUSY_BIT         = 0;
    localparam int          ST_WINDOW_BIT       = 1;
    localparam int          ST_PHASE_LSB        = 4;
    localparam int          ST_RDATA_LSB        = 8;
    localparam logic [2:0]  STRETCH_RESET       = 3'h1;
    localparam logic [7:0]  TA_KEY_FIRST        = 8'haa;
    localparam logic [7:0]  TA_KEY_SECOND       = 8'h55;
    localparam logic [2:0]  TA_WINDOW_CYCLES    = 3'h4;
    localparam logic [1:0]  PHASE_FIRST         = 2'h0;
    localparam logic [1:0]  PHASE_SECOND        = 2'h1;
    localparam logic [1:0]  PHASE_THIRD         = 2'h2;
    localparam logic [1:0]  PHASE_FOURTH        = 2'h3;
    typedef enum logic [1:0] {
        CYC_IDLE   = 2'b00,
        CYC_FETCH  = 2'b01,
        CYC_ACCESS = 2'b10
    } cycle_e;
endpackage : xdata_pkg

// >>> verilog/external_data_access_timing.sv
// Purpose: sequences one external data move with stretch and wait states
// Assumes: single clock, synchronous reset, ahb-lite slave with zero wait
// Notes:   wait pin is active high and passes a three-stage filter
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module external_data_access_timing #(
    parameter int HAS_WAIT_PIN = 1
) (
    input  wire logic          CLOCK,
    input  wire logic          RESET,
    input  wire logic          HSEL,
    input  wire logic [31:0]   HADDR,
    input  wire logic [1:0]    HTRANS,
    input  wire logic          HWRITE,
    input  wire logic [2:0]    HSIZE,
    input  wire logic [31:0]   HWDATA,
    input  wire logic          HREADY,
    output logic               HREADYOUT,
    output logic               HRESP,
    output logic [31:0]        HRDATA,
    input  wire logic          PORT_FOUR_BIT_ZERO,
    input  wire logic [7:0]    EXT_DATA_IN,
    output logic [7:0]         EXT_DATA_OUT,
    output logic               EXT_DATA_OE,
    output logic [15:0]        EXT_ADDR,
    output logic               READ_STROBE_N,
    output logic               STORE_STROBE_N,
    output logic               BUSY
);
    import xdata_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (HAS_WAIT_PIN != 0 && HAS_WAIT_PIN != 1) begin : g_bad_wait_pin
        $error("HAS_WAIT_PIN must be 0 or 1");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        cycle_e      state;
        logic [1:0]  phase;
        logic [2:0]  cyc_left;
        logic [2:0]  acc_stretch;
        logic        wait_hold;
        logic        cmd_store;
        logic        cmd_index;
        logic [2:0]  stretch;
        logic        wait_en;
        logic        ta_armed;
        logic [2:0]  ta_count;
        logic        ta_open;
        logic        data_pointer_select;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0]  idx;
        logic [7:0]  p2;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic [31:0] hrdata;
        logic        s1;
        logic        s2;
        logic        s3;
        logic        wait_lvl;
        logic [15:0] ext_addr;
        logic [7:0]  dout;
        logic        oe;
        logic        rd_n;
        logic        wr_n;
        logic        busy;
    } state_s;

    state_s r;
    state_s next_r;

    // ------------------------------------------------------------
    // local signals
    // ------------------------------------------------------------
    logic        addr_phase;
    logic        wr_hit;
    logic        wait_now;
    logic        strobe_on;
    logic [2:0]  sample_cyc;
    logic [31:0] read_word;

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    always_comb begin
        read_word = 32'h0;
        unique case (HADDR[7:0])
            OFF_CLOCK_CONTROL:  read_word[2:0] = r.stretch;                       // [R3]
            OFF_MEMORY_MAP:     read_word[WAIT_ENABLE_BIT] = r.wait_en;
            OFF_TIMED_ACCESS:   read_word[0] = r.ta_open;
            OFF_POINTER_SELECT: read_word[0] = r.data_pointer_select;                             // [R18]
            OFF_PRIMARY_PTR:    read_word[15:0] = r.ptr0;
            OFF_SECONDARY_PTR:  read_word[15:0] = r.ptr1;
            OFF_INDEX_REGISTER: read_word[7:0] = r.idx;
            OFF_PORT_TWO_LATCH: read_word[7:0] = r.p2;
            OFF_WRITE_DATA:     read_word[7:0] = r.wdata;
            OFF_COMMAND:        read_word[CMD_INDEX_BIT:CMD_STORE_BIT] =
                                    {r.cmd_index, r.cmd_store};
            OFF_STATUS: begin
                read_word[ST_BUSY_BIT] = (r.state != CYC_IDLE);
                read_word[ST_WINDOW_BIT] = r.ta_open;
                read_word[ST_PHASE_LSB +: 2] = r.phase;
                read_word[ST_RDATA_LSB +: 8] = r.rdata;
            end
            default:            read_word = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        addr_phase = HSEL && HREADY && HTRANS[1];
        wr_hit = r.dp_write;
        strobe_on = !r.rd_n || !r.wr_n;
        sample_cyc = (r.acc_stretch == 3'h0) ? 3'h0 : 3'h1;
        wait_now = (HAS_WAIT_PIN != 0) && r.wait_en && r.wait_lvl;              // [R8] [R9]

        // ------------------------------------------------------------
        // wait pin filter: first stage feeds only the second
        // ------------------------------------------------------------
        next_r.s1 = PORT_FOUR_BIT_ZERO;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.wait_lvl = r.s3;
        end

        // ------------------------------------------------------------
        // bus slave: capture address phase, answer with zero wait
        // ------------------------------------------------------------
        next_r.dp_write = addr_phase && HWRITE;
        next_r.dp_addr = HADDR[7:0];
        if (addr_phase && !HWRITE) begin
            next_r.hrdata = read_word;
        end

        // ------------------------------------------------------------
        // timed access window
        // ------------------------------------------------------------
        if (r.ta_count != 3'h0) begin
            next_r.ta_count = r.ta_count - 3'h1;
        end else begin
            next_r.ta_armed = 1'b0;
            next_r.ta_open = 1'b0;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_hit) begin
            unique case (r.dp_addr)
                OFF_CLOCK_CONTROL:  next_r.stretch = HWDATA[2:0];                 // [R3] [R6]
                OFF_MEMORY_MAP: begin
                    if (r.ta_open) begin
                        next_r.wait_en = HWDATA[WAIT_ENABLE_BIT];                  // [R15]
                        next_r.ta_open = 1'b0;
                    end
                end
                OFF_TIMED_ACCESS: begin
                    if (HWDATA[7:0] == TA_KEY_FIRST) begin
                        next_r.ta_armed = 1'b1;
                        next_r.ta_open = 1'b0;
                        next_r.ta_count = TA_WINDOW_CYCLES;
                    end else if (HWDATA[7:0] == TA_KEY_SECOND && r.ta_armed) begin
                        next_r.ta_armed = 1'b0;
                        next_r.ta_open = 1'b1;                                     // [R15]
                        next_r.ta_count = TA_WINDOW_CYCLES;
                    end else begin
                        next_r.ta_armed = 1'b0;
                        next_r.ta_open = 1'b0;
                    end
                end
                OFF_POINTER_SELECT: next_r.data_pointer_select = HWDATA[0];                       // [R18]
                OFF_PRIMARY_PTR:    next_r.ptr0 = HWDATA[15:0];
                OFF_SECONDARY_PTR:  next_r.ptr1 = HWDATA[15:0];
                OFF_INDEX_REGISTER: next_r.idx = HWDATA[7:0];
                OFF_PORT_TWO_LATCH: next_r.p2 = HWDATA[7:0];
                OFF_WRITE_DATA:     next_r.wdata = HWDATA[7:0];
                OFF_COMMAND: begin
                    if (r.state == CYC_IDLE) begin
                        next_r.cmd_store = HWDATA[CMD_STORE_BIT];
                        next_r.cmd_index = HWDATA[CMD_INDEX_BIT];
                        next_r.acc_stretch = r.stretch;
                        next_r.state = CYC_FETCH;                                  // [R1]
                        next_r.phase = PHASE_FIRST;
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // move sequencer
        // ------------------------------------------------------------
        unique case (r.state)
            CYC_IDLE: begin
            end
            CYC_FETCH: begin
                next_r.phase = r.phase + 2'h1;                                     // [R16]
                if (r.phase == PHASE_FOURTH) begin
                    next_r.state = CYC_ACCESS;                                     // [R1] [R2]
                    next_r.cyc_left = r.acc_stretch;                               // [R4] [R5]
                    next_r.wait_hold = 1'b0;
                    next_r.ext_addr = r.cmd_index ? {r.p2, r.idx} :                // [R17]
                                      (r.data_pointer_select ? r.ptr1 : r.ptr0);                   // [R18]
                    next_r.dout = r.wdata;
                    next_r.oe = r.cmd_store;
                end
            end
            CYC_ACCESS: begin
                next_r.phase = r.phase + 2'h1;                                     // [R16]
                // strobe start: second state at stretch 0, else third state
                if (r.acc_stretch == 3'h0 && r.phase == PHASE_FIRST
                    && r.cyc_left == 3'h0 && !strobe_on) begin
                    next_r.rd_n = r.cmd_store;                                     // [R7]
                    next_r.wr_n = !r.cmd_store;
                end else if (r.acc_stretch != 3'h0 && r.phase == PHASE_SECOND
                             && r.cyc_left == r.acc_stretch && !strobe_on) begin
                    next_r.rd_n = r.cmd_store;                                     // [R7]
                    next_r.wr_n = !r.cmd_store;
                end
                // third-state wait sample ahead of the strobe release
                if (r.phase == PHASE_THIRD && r.cyc_left == sample_cyc && strobe_on) begin
                    next_r.wait_hold = wait_now;                                   // [R11] [R14]
                end
                // strobe release: end of third state at stretch 0, else second
                if (r.cyc_left == 3'h0 && strobe_on
                    && ((r.acc_stretch == 3'h0 && r.phase == PHASE_THIRD && !wait_now)
                        || (r.acc_stretch != 3'h0 && r.phase == PHASE_SECOND))) begin
                    next_r.rd_n = 1'b1;                                            // [R7]
                    next_r.wr_n = 1'b1;
                    if (!r.cmd_store) begin
                        next_r.rdata = EXT_DATA_IN;
                    end
                end
                if (r.phase == PHASE_FOURTH) begin
                    if (r.wait_hold) begin
                        next_r.wait_hold = 1'b0;                                   // [R12] [R13] [R19]
                    end else if (r.cyc_left == 3'h0) begin
                        next_r.state = CYC_IDLE;                                   // [R4] [R10]
                        next_r.oe = 1'b0;
                    end else begin
                        next_r.cyc_left = r.cyc_left - 3'h1;                       // [R10]
                    end
                end
            end
            default: begin
                next_r.state = CYC_IDLE;
            end
        endcase

        // registered busy flag, keeps BUSY off the state decode
        next_r.busy = (next_r.state != CYC_IDLE);

        // ------------------------------------------------------------
        // reset
        // ------------------------------------------------------------
        if (RESET) begin
            next_r = '0;
            next_r.stretch = STRETCH_RESET;                                        // [R6]
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        r <= next_r;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign HREADYOUT      = 1'b1;
    assign HRESP          = 1'b0;
    assign HRDATA         = r.hrdata;
    assign EXT_DATA_OUT   = r.dout;
    assign EXT_DATA_OE    = r.oe;
    assign EXT_ADDR       = r.ext_addr;
    assign READ_STROBE_N  = r.rd_n;
    assign STORE_STROBE_N = r.wr_n;
    assign BUSY           = r.busy;

endmodule : external_data_access_timing

// >>> sim/external_data_access_timing_properties.sv
// Purpose: timing properties of the move sequencer
// Assumes: sees only the top ports
// Notes:   waits add whole machine cycles
`timescale 1ns/100ps
module external_data_access_timing_properties #(
    parameter int HAS_WAIT_PIN = 1
) (
    input wire logic        CLOCK,
    input wire logic        RESET,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        EXT_DATA_OE,
    input wire logic [15:0] EXT_ADDR,
    input wire logic        READ_STROBE_N,
    input wire logic        STORE_STROBE_N,
    input wire logic        BUSY
);
    // ----------------
    // helper counters
    // ----------------
    logic [9:0] busy_cnt;
    logic [9:0] low_cnt;
    wire        strobe_on = !(READ_STROBE_N && STORE_STROBE_N);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    always_ff @(posedge CLOCK) begin
        busy_cnt <= (RESET || !BUSY) ? 10'h0 : busy_cnt + 10'h1;
        low_cnt  <= (RESET || !strobe_on) ? 10'h0 : low_cnt + 10'h1;
    end
    sequence fetch_quiet;
        (READ_STROBE_N && STORE_STROBE_N) [*4];
    endsequence
    sequence strobe_done;
        $fell(strobe_on);
    endsequence
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus slave not ready or not okay");
    a_one_strobe: assert property (READ_STROBE_N || STORE_STROBE_N)
        else $error("both strobes active");
    a_strobe_busy: assert property (strobe_on |-> BUSY)
        else $error("strobe outside a move");
    a_fetch_first: assert property ($rose(BUSY) |-> fetch_quiet)
        else $error("strobe during opcode fetch");
    a_move_length: assert property ($fell(BUSY) |-> busy_cnt >= 8 && busy_cnt[1:0] == 2'h0)
        else $error("move not whole machine cycles");
    a_pinless_bound: assert property ($fell(BUSY) |-> HAS_WAIT_PIN != 0 || busy_cnt <= 36)
        else $error("move too long without wait pin");
    a_strobe_width: assert property (strobe_done |-> low_cnt == 2 ||
        (low_cnt >= 4 && low_cnt[1:0] == 2'h0)) else $error("strobe width wrong");
    a_addr_steady: assert property (strobe_on |-> $stable(EXT_ADDR))
        else $error("address moved under strobe");
    a_store_drive: assert property (!STORE_STROBE_N |-> EXT_DATA_OE)
        else $error("store without data drive");
    a_read_quiet: assert property (!READ_STROBE_N |-> !EXT_DATA_OE)
        else $error("data driven during read");
    a_reset_idle: assert property (disable iff (1'b0) RESET |=>
        READ_STROBE_N && STORE_STROBE_N && !BUSY && !EXT_DATA_OE) else $error("not idle at reset");
endmodule : external_data_access_timing_properties

// >>> sim/ext_memory_model.sv
// Purpose: external data memory with a wait output
// Assumes: low address byte selects the byte
// Notes:   slow mode holds wait for hold_clks strobe clocks
`timescale 1ns/100ps
module ext_memory_model (
    input  wire logic        clock,
    input  wire logic [15:0] ext_addr,
    input  wire logic        read_strobe_n,
    input  wire logic        store_strobe_n,
    input  wire logic [7:0]  ext_data_out,
    input  wire logic        ext_data_oe,
    input  wire logic        slow,
    input  wire logic [7:0]  hold_clks,
    output logic [7:0]       ext_data_in,
    output logic             wait_req
);
    logic [7:0] mem [0:255];
    logic [7:0] last    = 8'h00;
    logic [7:0] low_cnt = 8'h00;
    initial begin
        wait_req = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // released bus shows the inverse of the last byte
    assign ext_data_in = read_strobe_n ? ~last : mem[ext_addr[7:0]];
    always @(posedge clock) begin
        if (!read_strobe_n) begin
            last <= mem[ext_addr[7:0]];
        end
        if (!store_strobe_n && ext_data_oe) begin
            mem[ext_addr[7:0]] <= ext_data_out;
        end
        low_cnt  <= (read_strobe_n && store_strobe_n) ? 8'h00 : low_cnt + 8'h1;
        wait_req <= slow && (low_cnt < hold_clks);
    end
endmodule : ext_memory_model

// >>> sim/test_external_data_access_timing.sv
// Purpose: self-checking bench for the move sequencer
// Assumes: zero-wait slave, wait pin fitted
// Notes:   moves timed by counting busy and strobe clocks
`timescale 1ns/100ps
module test_external_data_access_timing;
    import xdata_pkg::*;
    logic        CLOCK = 1'b0;
    logic        RESET = 1'b1;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic        HREADYOUT, HRESP, EXT_DATA_OE, READ_STROBE_N, STORE_STROBE_N, BUSY, wait_pin;
    logic [7:0]  EXT_DATA_IN, EXT_DATA_OUT, wdat;
    logic [15:0] EXT_ADDR, pri, sec, idx_ptr;
    logic        slow = 1'b0;
    logic        data_pointer_select = 1'b0;
    int          seed, error_cnt = 0, compares = 0;
    initial forever #50 CLOCK = ~CLOCK;
    external_data_access_timing #(.HAS_WAIT_PIN(1)) i_dut (.CLOCK(CLOCK), .RESET(RESET),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .PORT_FOUR_BIT_ZERO(wait_pin), .EXT_DATA_IN(EXT_DATA_IN),
        .EXT_DATA_OUT(EXT_DATA_OUT), .EXT_DATA_OE(EXT_DATA_OE), .EXT_ADDR(EXT_ADDR),
        .READ_STROBE_N(READ_STROBE_N), .STORE_STROBE_N(STORE_STROBE_N), .BUSY(BUSY));
    ext_memory_model i_mem (.clock(CLOCK), .ext_addr(EXT_ADDR), .read_strobe_n(READ_STROBE_N),
        .store_strobe_n(STORE_STROBE_N), .ext_data_out(EXT_DATA_OUT), .ext_data_oe(EXT_DATA_OE),
        .slow(slow), .hold_clks(8'd14), .ext_data_in(EXT_DATA_IN), .wait_req(wait_pin));
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HADDR  <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk("register", exp, r);
    endtask : rd
    function automatic int move_len(input int s);
        return 4 * (s + 2);
    endfunction : move_len
    function automatic int width(input int s);
        return (s == 0) ? 2 : 4 * s;
    endfunction : width
    function automatic logic [15:0] exp_addr(input logic [1:0] cmd);
        return cmd[CMD_INDEX_BIT] ? idx_ptr : (data_pointer_select ? sec : pri);
    endfunction : exp_addr
    task automatic move(input logic [1:0] cmd, input int s, input bit waits);
        int          b = 0;
        int          w = 0;
        int          t = 0;
        logic [15:0] a = 16'h0;
        logic [31:0] r;
        data_pointer_select  = 1'($random(seed));
        wdat = 8'($random(seed));
        wr(OFF_POINTER_SELECT, {31'h0, data_pointer_select});
        wr(OFF_WRITE_DATA, {24'h0, wdat});
        wr(OFF_COMMAND, {30'h0, cmd});
        #1;
        while (BUSY !== 1'b1 && t < 8) begin
            @(posedge CLOCK);
            #1;
            t++;
        end
        while (BUSY === 1'b1 && b < 400) begin
            if ((READ_STROBE_N & STORE_STROBE_N) === 1'b0) begin
                w++;
                a = EXT_ADDR;
            end
            b++;
            @(posedge CLOCK);
            #1;
        end
        @(posedge CLOCK);
        chk("move_ended", 1, b < 400);
        if (waits) begin
            chk("wait_cycles", 0, (b - move_len(s)) % 4);
            chk("wait_added", 1, b > move_len(s));
            chk("wait_strobe", b - move_len(s) + width(s), w);
        end else begin
            chk("move_clocks", move_len(s), b);
            chk("strobe_clocks", width(s), w);
        end
        chk("ext_addr", {16'h0, exp_addr(cmd)}, {16'h0, a});
        if (cmd[CMD_STORE_BIT]) begin
            chk("stored", {24'h0, wdat}, {24'h0, i_mem.mem[a[7:0]]});
        end else begin
            bus(1'b0, OFF_STATUS, 32'h0, r);
            chk("read_data", {24'h0, i_mem.mem[a[7:0]]}, {24'h0, r[ST_RDATA_LSB +: 8]});
        end
    endtask : move
    task automatic final_report;
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    // ----------------
    // sequence
    // ----------------
    initial begin
        #2000000;
        error_cnt++;
        final_report;
    end
    initial begin
        seed = 12;
        repeat (5) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        rd(OFF_CLOCK_CONTROL, 32'h1);
        wr(OFF_POINTER_SELECT, 32'hff);
        rd(OFF_POINTER_SELECT, 32'h1);
        rd(8'h40, 32'h0);
        wr(OFF_MEMORY_MAP, 32'h80);
        rd(OFF_MEMORY_MAP, 32'h0);
        pri     = 16'($random(seed));
        sec     = 16'($random(seed));
        idx_ptr = 16'($random(seed));
        wr(OFF_PRIMARY_PTR, {16'h0, pri});
        wr(OFF_SECONDARY_PTR, {16'h0, sec});
        wr(OFF_INDEX_REGISTER, {24'h0, idx_ptr[7:0]});
        wr(OFF_PORT_TWO_LATCH, {24'h0, idx_ptr[15:8]});
        for (int s = 0; s < 8; s++) begin
            wr(OFF_CLOCK_CONTROL, s);
            rd(OFF_CLOCK_CONTROL, s);
            move(2'($random(seed)), s, 1'b0);
        end
        slow <= 1'b1;
        move(2'h0, 7, 1'b0);
        wr(OFF_CLOCK_CONTROL, 32'h2);
        wr(OFF_TIMED_ACCESS, {24'h0, TA_KEY_FIRST});
        wr(OFF_TIMED_ACCESS, {24'h0, TA_KEY_SECOND});
        wr(OFF_MEMORY_MAP, 32'h80);
        rd(OFF_MEMORY_MAP, 32'h80);
        move(2'h1, 2, 1'b1);
        move(2'h2, 2, 1'b1);
        slow <= 1'b0;
        move(2'h3, 2, 1'b0);
        wr(OFF_COMMAND, 32'h0);
        RESET <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        chk("busy_reset", 0, BUSY);
        rd(OFF_CLOCK_CONTROL, 32'h1);
        final_report;
    end
endmodule : test_external_data_access_timing
bind external_data_access_timing external_data_access_timing_properties #(
    .HAS_WAIT_PIN(HAS_WAIT_PIN)) i_props (.CLOCK(CLOCK), .RESET(RESET),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_DATA_OE(EXT_DATA_OE), .EXT_ADDR(EXT_ADDR),
    .READ_STROBE_N(READ_STROBE_N), .STORE_STROBE_N(STORE_STROBE_N), .BUSY(BUSY));
